/* logic/framer_ctrl_pkg.sv */
/*
 * Constants and carrier types for the framer control register bank.
 * Assumes a 32-bit APB master on the register side and a single clock.
 */
`default_nettype none

package framer_ctrl_pkg;

    // APB word offsets (byte addresses)
    localparam logic [11:0] LINE_INTERFACE_CONTROL_ADDR   = 12'h000;
    localparam logic [11:0] GENERAL_PIN_CONTROL_ADDR      = 12'h004;
    localparam logic [11:0] FRAMING_SELECT_ADDR           = 12'h008;
    localparam logic [11:0] RECEIVE_SIGNALLING_ARRAY_ADDR = 12'h00C;

    // Values after reset
    localparam logic [7:0] LINE_INTERFACE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] GENERAL_PIN_CONTROL_RESET    = 8'hF0;
    localparam logic [7:0] FRAMING_SELECT_RESET         = 8'h00;

    // Placement of each byte register inside the control carrier
    localparam int LINE_LSB    = 0;
    localparam int PIN_LSB     = 8;
    localparam int FRAMING_LSB = 16;

    // Field positions inside each byte register
    localparam int TX_ZS_DISABLE_BIT   = 1;
    localparam int RX_ZS_DISABLE_BIT   = 0;
    localparam int PIN_DIR_LSB         = 4;
    localparam int PIN_VALUE_LSB       = 0;
    localparam int SF_SIG_UPDATE_BIT   = 7;
    localparam int FORCE_CRC_BIT       = 6;
    localparam int JAPAN_BIT           = 5;
    localparam int SINGLE_CAND_BIT     = 4;

    // Framing mode code that selects extended superframe
    localparam logic [2:0] FRAMING_MODE_ESF = 3'h0;

    localparam int PIN_COUNT = 4;

    typedef struct packed {
        logic       sf_sig_update;
        logic       force_crc_error;
        logic       japan_variant_select;
        logic       single_candidate_sync;
        logic       fast_sync;
        logic [2:0] framing_mode;
        logic [3:0] pin_direction;
        logic [3:0] pin_value;
        logic [5:0] line_other;
        logic       tx_zs_disable;
        logic       rx_zs_disable;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = {FRAMING_SELECT_RESET,
                                    GENERAL_PIN_CONTROL_RESET,
                                    LINE_INTERFACE_CONTROL_RESET};

endpackage

`default_nettype wire

/* logic/t1_framer_control_bank.sv */
/*
 * Control register bank of a single-channel T1/J1 framer: line code
 * selection, a four-pin general purpose port, framing select options and
 * the superframe-aligned robbed-bit signalling update.
 * Assumes an APB master, inputs synchronous to clock, and framer datapaths
 * that act on the control outputs and supply superframe boundary strobes.
 */
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module t1_framer_control_bank #(
    parameter int SIG_WIDTH = 4
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    input  wire logic [3:0]              gpio_in,
    output logic [3:0]                   gpio_out,
    output logic [3:0]                   gpio_oe,
    output framer_ctrl_pkg::ctrl_t       ctrl,
    output logic                         tx_zero_sub_enable,
    output logic                         rx_zero_sub_enable,
    output logic                         j1_superframe,
    output logic                         j1_extended_superframe,
    input  wire logic                    rx_sig_valid,
    input  wire logic [SIG_WIDTH-1:0]    rx_sig_in,
    input  wire logic                    rx_sf_boundary,
    output logic [SIG_WIDTH-1:0]         receive_signalling_out,
    input  wire logic [SIG_WIDTH-1:0]    tx_sig_in,
    input  wire logic                    tx_sf_boundary,
    output logic [SIG_WIDTH-1:0]         tx_sig_out
);

    if (SIG_WIDTH < 1 || SIG_WIDTH > 32)
    begin : g_bad_width
        $error("SIG_WIDTH must lie between 1 and 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, write lands at the edge pready is seen

    logic                 pready_r;
    logic                 pready_nxt;
    logic [31:0]          prdata_r;
    logic [31:0]          prdata_nxt;
    logic                 pslverr_r;
    logic                 pslverr_nxt;
    logic                 addr_hit;
    logic                 access_done;
    logic                 wr_done;
    framer_ctrl_pkg::ctrl_t ctrl_r;
    framer_ctrl_pkg::ctrl_t ctrl_nxt;
    logic [SIG_WIDTH-1:0] rx_out_r;

    assign access_done = psel && penable && pready_r;
    assign wr_done     = access_done && pwrite && addr_hit;

    always_comb
    begin
        addr_hit = (paddr == framer_ctrl_pkg::LINE_INTERFACE_CONTROL_ADDR)
                || (paddr == framer_ctrl_pkg::GENERAL_PIN_CONTROL_ADDR)
                || (paddr == framer_ctrl_pkg::FRAMING_SELECT_ADDR)
                || (paddr == framer_ctrl_pkg::RECEIVE_SIGNALLING_ARRAY_ADDR);
        pready_nxt  = psel && penable && !pready_r;
        pslverr_nxt = pready_nxt && !addr_hit;
        prdata_nxt  = prdata_r;
        if (pready_nxt && !pwrite)
        begin
            prdata_nxt = 32'h0000_0000;
            case (paddr)
                framer_ctrl_pkg::LINE_INTERFACE_CONTROL_ADDR:
                    prdata_nxt[7:0] = ctrl_r[framer_ctrl_pkg::LINE_LSB +: 8];
                framer_ctrl_pkg::GENERAL_PIN_CONTROL_ADDR:
                    prdata_nxt[7:0] = {ctrl_r.pin_direction,
                                       (ctrl_r.pin_value & ctrl_r.pin_direction)
                                       | (gpio_in & ~ctrl_r.pin_direction)};
                framer_ctrl_pkg::FRAMING_SELECT_ADDR:
                    prdata_nxt[7:0] = ctrl_r[framer_ctrl_pkg::FRAMING_LSB +: 8];
                framer_ctrl_pkg::RECEIVE_SIGNALLING_ARRAY_ADDR:
                    prdata_nxt[SIG_WIDTH-1:0] = rx_out_r;
                default:
                    prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign pready  = pready_r;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    logic j1_sf_r;
    logic j1_sf_nxt;
    logic j1_esf_r;
    logic j1_esf_nxt;
    logic tx_zs_en_r;
    logic tx_zs_en_nxt;
    logic rx_zs_en_r;
    logic rx_zs_en_nxt;
    logic [framer_ctrl_pkg::PIN_COUNT-1:0] pin_value_nxt;

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_done && paddr == framer_ctrl_pkg::LINE_INTERFACE_CONTROL_ADDR)
        begin
            ctrl_nxt[framer_ctrl_pkg::LINE_LSB +: 8] = pwdata[7:0];
        end
        if (wr_done && paddr == framer_ctrl_pkg::GENERAL_PIN_CONTROL_ADDR)
        begin
            ctrl_nxt.pin_direction = pwdata[framer_ctrl_pkg::PIN_DIR_LSB +: 4];
        end
        if (wr_done && paddr == framer_ctrl_pkg::FRAMING_SELECT_ADDR)
        begin
            ctrl_nxt[framer_ctrl_pkg::FRAMING_LSB +: 8] = pwdata[7:0];
        end
        // Data bits follow the direction held before the write
        ctrl_nxt.pin_value = pin_value_nxt;
        // Zero substitution off means plain AMI on that path
        tx_zs_en_nxt = !ctrl_nxt.tx_zs_disable;
        rx_zs_en_nxt = !ctrl_nxt.rx_zs_disable;
        j1_esf_nxt   = ctrl_nxt.japan_variant_select
                    && (ctrl_nxt.framing_mode == framer_ctrl_pkg::FRAMING_MODE_ESF);
        j1_sf_nxt    = ctrl_nxt.japan_variant_select && !j1_esf_nxt;
    end

    // Per-pin data bit: only pins that are outputs before the write take data
    // A pin turned to output keeps its old data until software writes it again
    for (genvar i = 0; i < framer_ctrl_pkg::PIN_COUNT; i++)
    begin : g_pin
        logic value_nxt;
        always_comb
        begin
            value_nxt = ctrl_r.pin_value[i];
            if (wr_done && paddr == framer_ctrl_pkg::GENERAL_PIN_CONTROL_ADDR
                && ctrl_r.pin_direction[i])
            begin
                value_nxt = pwdata[framer_ctrl_pkg::PIN_VALUE_LSB + i];
            end
        end
        assign pin_value_nxt[i] = value_nxt;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ctrl_r     <= framer_ctrl_pkg::CTRL_RESET;
            j1_sf_r    <= 1'b0;
            j1_esf_r   <= 1'b0;
            tx_zs_en_r <= 1'b1;
            rx_zs_en_r <= 1'b1;
        end
        else
        begin
            ctrl_r            <= ctrl_nxt;
            j1_sf_r           <= j1_sf_nxt;
            j1_esf_r          <= j1_esf_nxt;
            tx_zs_en_r        <= tx_zs_en_nxt;
            rx_zs_en_r        <= rx_zs_en_nxt;
        end
    end

    // Pins drive the held data only while configured as outputs
    assign ctrl                   = ctrl_r;
    assign gpio_out               = ctrl_r.pin_value;
    assign gpio_oe                = ctrl_r.pin_direction;
    assign tx_zero_sub_enable     = tx_zs_en_r;
    assign rx_zero_sub_enable     = rx_zs_en_r;
    assign j1_superframe          = j1_sf_r;
    assign j1_extended_superframe = j1_esf_r;

    ////////////////////////////////////////////////////////////////////////////
    // Robbed-bit signalling update

    logic [SIG_WIDTH-1:0] rx_hold_r;
    logic [SIG_WIDTH-1:0] rx_hold_nxt;
    logic [SIG_WIDTH-1:0] rx_out_nxt;
    logic [SIG_WIDTH-1:0] tx_out_r;
    logic [SIG_WIDTH-1:0] tx_out_nxt;

    // A value arriving on the boundary cycle itself is released at once
    always_comb
    begin
        rx_hold_nxt = rx_sig_valid ? rx_sig_in : rx_hold_r;
        rx_out_nxt  = rx_out_r;
        if (!ctrl_r.sf_sig_update || rx_sf_boundary)
        begin
            rx_out_nxt = rx_hold_nxt;
        end
        tx_out_nxt = tx_out_r;
        if (!ctrl_r.sf_sig_update || tx_sf_boundary)
        begin
            tx_out_nxt = tx_sig_in;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rx_hold_r <= '0;
            rx_out_r  <= '0;
            tx_out_r  <= '0;
        end
        else
        begin
            rx_hold_r <= rx_hold_nxt;
            rx_out_r  <= rx_out_nxt;
            tx_out_r  <= tx_out_nxt;
        end
    end

    assign receive_signalling_out = rx_out_r;
    assign tx_sig_out             = tx_out_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_tx_zs_gate: assert property (@(posedge clock) disable iff (rst)
        wr_done && paddr == framer_ctrl_pkg::LINE_INTERFACE_CONTROL_ADDR
        |=> tx_zero_sub_enable == !$past(pwdata[1]))
        else $error("transmit encoder gate does not follow bit 1");

    chk_rx_zs_gate: assert property (@(posedge clock) disable iff (rst)
        wr_done && paddr == framer_ctrl_pkg::LINE_INTERFACE_CONTROL_ADDR
        |=> rx_zero_sub_enable == !$past(pwdata[0]))
        else $error("receive decoder gate does not follow bit 0");

    chk_pin_direction: assert property (@(posedge clock) disable iff (rst)
        wr_done && paddr == framer_ctrl_pkg::GENERAL_PIN_CONTROL_ADDR
        |=> gpio_oe == $past(pwdata[7:4]))
        else $error("pin direction does not follow bits 7-4");

    chk_input_pin_read: assert property (@(posedge clock) disable iff (rst)
        pready_nxt && !pwrite && paddr == framer_ctrl_pkg::GENERAL_PIN_CONTROL_ADDR
        |=> ((prdata[3:0] ^ $past(gpio_in)) & ~$past(gpio_oe)) == 4'h0)
        else $error("input pin level not returned on read");

    chk_input_write_ignored: assert property (@(posedge clock) disable iff (rst)
        wr_done |=> ((gpio_out ^ $past(gpio_out)) & ~$past(gpio_oe)) == 4'h0)
        else $error("write changed data of an input pin");

    chk_output_pin_drive: assert property (@(posedge clock) disable iff (rst)
        wr_done && paddr == framer_ctrl_pkg::GENERAL_PIN_CONTROL_ADDR
        |=> ((gpio_out ^ $past(pwdata[3:0])) & $past(gpio_oe)) == 4'h0)
        else $error("output pin does not drive written data");

    chk_rx_sig_defer: assert property (@(posedge clock) disable iff (rst)
        ctrl_r.sf_sig_update && !rx_sf_boundary |=> $stable(receive_signalling_out))
        else $error("receive signalling changed off a superframe boundary");

    chk_rx_sig_now: assert property (@(posedge clock) disable iff (rst)
        !ctrl_r.sf_sig_update && rx_sig_valid |=> receive_signalling_out == $past(rx_sig_in))
        else $error("receive signalling not refreshed at once");

    chk_tx_sig_defer: assert property (@(posedge clock) disable iff (rst)
        ctrl_r.sf_sig_update && !tx_sf_boundary |=> $stable(tx_sig_out))
        else $error("transmit signalling changed off a superframe boundary");

    chk_crc_force: assert property (@(posedge clock) disable iff (rst)
        wr_done && paddr == framer_ctrl_pkg::FRAMING_SELECT_ADDR
        |=> ctrl.force_crc_error == $past(pwdata[6]) && ctrl.sf_sig_update == $past(pwdata[7]))
        else $error("framing select bits not taken from write");

    chk_j1_format: assert property (@(posedge clock) disable iff (rst)
        !(j1_superframe && j1_extended_superframe)
        && ((j1_superframe || j1_extended_superframe) == ctrl.japan_variant_select))
        else $error("J1 format select inconsistent with J1 bit");

    chk_unmapped_err: assert property (@(posedge clock) disable iff (rst)
        psel && penable && !pready && !addr_hit |=> pready && pslverr)
        else $error("unmapped access not answered with error");

    // Read data is compared with the register state seen at the capturing edge
    chk_tx_sig_now: assert property (@(posedge clock) disable iff (rst)
        !ctrl_r.sf_sig_update |=> tx_sig_out == $past(tx_sig_in))
        else $error("transmit signalling not sent at once");

    chk_rx_sig_boundary: assert property (@(posedge clock) disable iff (rst)
        ctrl_r.sf_sig_update && rx_sf_boundary && !rx_sig_valid
        |=> receive_signalling_out == $past(rx_hold_r))
        else $error("receive signalling not released at the boundary");

    chk_tx_sig_boundary: assert property (@(posedge clock) disable iff (rst)
        ctrl_r.sf_sig_update && tx_sf_boundary |=> tx_sig_out == $past(tx_sig_in))
        else $error("transmit signalling not sent at the boundary");

    chk_line_readback: assert property (@(posedge clock) disable iff (rst)
        pready_nxt && !pwrite && paddr == framer_ctrl_pkg::LINE_INTERFACE_CONTROL_ADDR
        |=> prdata == {24'h00_0000, $past(ctrl[7:0])})
        else $error("line control read does not return stored value");

    chk_framing_readback: assert property (@(posedge clock) disable iff (rst)
        pready_nxt && !pwrite && paddr == framer_ctrl_pkg::FRAMING_SELECT_ADDR
        |=> prdata == {24'h00_0000, $past(ctrl[23:16])})
        else $error("framing select read does not return stored value");

    chk_output_pin_read: assert property (@(posedge clock) disable iff (rst)
        pready_nxt && !pwrite && paddr == framer_ctrl_pkg::GENERAL_PIN_CONTROL_ADDR
        |=> ((prdata[3:0] ^ $past(gpio_out)) & $past(gpio_oe)) == 4'h0
            && prdata[7:4] == $past(gpio_oe))
        else $error("output pin data or direction not returned on read");

    chk_unmapped_write_dropped: assert property (@(posedge clock) disable iff (rst)
        psel && penable && pready && pwrite && !addr_hit |=> $stable(ctrl))
        else $error("unmapped write changed a control register");

    chk_read_upper_zero: assert property (@(posedge clock) disable iff (rst)
        pready_nxt && !pwrite && paddr != framer_ctrl_pkg::RECEIVE_SIGNALLING_ARRAY_ADDR
        |=> prdata[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");

    chk_zs_gate_hold: assert property (@(posedge clock) disable iff (rst)
        !(wr_done && paddr == framer_ctrl_pkg::LINE_INTERFACE_CONTROL_ADDR)
        |=> $stable(tx_zero_sub_enable) && $stable(rx_zero_sub_enable))
        else $error("line code gate changed without a write");

    chk_j1_decode: assert property (@(posedge clock) disable iff (rst)
        j1_extended_superframe == (ctrl.japan_variant_select
            && ctrl.framing_mode == framer_ctrl_pkg::FRAMING_MODE_ESF))
        else $error("J1 extended superframe select does not follow mode bits");

    chk_ready_one_wait: assert property (@(posedge clock) disable iff (rst)
        psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");

endmodule // t1_framer_control_bank

`default_nettype wire

/* test/t1_framer_control_bank_tb_top.sv */
/*
 * Self-checking bench for the framer control register bank: APB register
 * access, pin port, line code enables, J1 decode and signalling update.
 * Assumes the bank answers APB with its own pready; the bench plays the pins.
 */
`timescale 1ns/1ns
`default_nettype none

module t1_framer_control_bank_tb_top;

    localparam int          TIMEOUT_CYCLES = 2000;
    localparam logic [11:0] LINE_A = framer_ctrl_pkg::LINE_INTERFACE_CONTROL_ADDR;
    localparam logic [11:0] PIN_A  = framer_ctrl_pkg::GENERAL_PIN_CONTROL_ADDR;
    localparam logic [11:0] FS_A   = framer_ctrl_pkg::FRAMING_SELECT_ADDR;
    localparam logic [11:0] SIG_A  = framer_ctrl_pkg::RECEIVE_SIGNALLING_ARRAY_ADDR;
    localparam logic [7:0]  FS_TABLE [4] = '{8'hB0, 8'h21, 8'h46, 8'h00};

    logic                   clock;
    logic                   rst;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [11:0]            paddr;
    logic [31:0]            pwdata;
    logic                   pready;
    logic [31:0]            prdata;
    logic                   pslverr;
    logic [3:0]             gpio_in;
    logic [3:0]             gpio_out;
    logic [3:0]             gpio_oe;
    framer_ctrl_pkg::ctrl_t ctrl;
    logic                   tx_zero_sub_enable;
    logic                   rx_zero_sub_enable;
    logic                   j1_superframe;
    logic                   j1_extended_superframe;
    logic                   rx_sig_valid;
    logic [3:0]             rx_sig_in;
    logic                   rx_sf_boundary;
    logic [3:0]             receive_signalling_out;
    logic [3:0]             tx_sig_in;
    logic                   tx_sf_boundary;
    logic [3:0]             tx_sig_out;
    logic [31:0]            rdata;
    logic                   rerr;
    logic [7:0]             d;
    logic                   j1_esf;
    int                     miscompares = 0;
    int                     check_count = 0;
    int                     cycles = 0;

    t1_framer_control_bank #(.SIG_WIDTH(4)) t1_framer_control_bank_i (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .ctrl(ctrl), .tx_zero_sub_enable(tx_zero_sub_enable),
        .rx_zero_sub_enable(rx_zero_sub_enable), .j1_superframe(j1_superframe),
        .j1_extended_superframe(j1_extended_superframe), .rx_sig_valid(rx_sig_valid),
        .rx_sig_in(rx_sig_in), .rx_sf_boundary(rx_sf_boundary),
        .receive_signalling_out(receive_signalling_out), .tx_sig_in(tx_sig_in),
        .tx_sf_boundary(tx_sf_boundary), .tx_sig_out(tx_sig_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // A hung handshake ends here rather than stalling the run
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES)
        begin
            miscompares++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until the rising edge that samples pready high; data taken there
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] addr, input logic [7:0] v);
        apb(1'b1, addr, {24'h0, v});
        @(negedge clock);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check_val(what, exp, rdata);
    endtask

    // All bits of the receive input are set to the inverse after the valid cycle, not left at the old value
    task automatic sig_send(input logic [3:0] rv, input logic [3:0] tv);
        @(posedge clock);
        rx_sig_valid <= 1'b1;
        rx_sig_in    <= rv;
        tx_sig_in    <= tv;
        @(posedge clock);
        rx_sig_valid <= 1'b0;
        rx_sig_in    <= ~rv;
        @(negedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        gpio_in = 4'h0;
        rx_sig_valid = 1'b0;
        rx_sig_in = 4'h0;
        rx_sf_boundary = 1'b0;
        tx_sig_in = 4'h0;
        tx_sf_boundary = 1'b0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check_val("enables", 32'h3, {30'h0, tx_zero_sub_enable, rx_zero_sub_enable});
        check_val("pins", 32'hF0, {24'h0, gpio_oe, gpio_out});
        rd_chk("line reset", LINE_A, 32'h00);
        rd_chk("pin reset", PIN_A, 32'hF0);
        rd_chk("framing reset", FS_A, 32'h00);
        $display("test reset done");

        for (int i = 1; i <= 4; i++)
        begin
            d = 8'(i % 4);
            wr(LINE_A, d);
            check_val("tx encoder", {31'h0, ~d[1]}, {31'h0, tx_zero_sub_enable});
            check_val("rx decoder", {31'h0, ~d[0]}, {31'h0, rx_zero_sub_enable});
            rd_chk("line readback", LINE_A, {24'h0, d});
        end
        $display("test line code done");

        wr(PIN_A, 8'h5A);
        check_val("pin oe", 32'h5, {28'h0, gpio_oe});
        check_val("pin drive", 32'h0, {28'h0, gpio_out & gpio_oe});
        @(posedge clock);
        gpio_in <= 4'h6;
        rd_chk("pin read a", PIN_A, 32'h52);
        @(posedge clock);
        gpio_in <= 4'h9;
        rd_chk("pin read b", PIN_A, 32'h58);
        wr(PIN_A, 8'h55);
        rd_chk("pin read c", PIN_A, 32'h5D);
        wr(PIN_A, 8'hF0);
        check_val("pin out", 32'hFA, {24'h0, gpio_oe, gpio_out});
        rd_chk("pin read d", PIN_A, 32'hFA);
        $display("test pins done");

        for (int i = 0; i < 4; i++)
        begin
            d = FS_TABLE[i];
            wr(FS_A, d);
            j1_esf = (d[2:0] == framer_ctrl_pkg::FRAMING_MODE_ESF);
            check_val("framing fields", {28'h0, d[7:4]}, {28'h0, ctrl.sf_sig_update,
                ctrl.force_crc_error, ctrl.japan_variant_select,
                ctrl.single_candidate_sync});
            check_val("j1 format", {30'h0, d[5] & j1_esf, d[5] & ~j1_esf},
                {30'h0, j1_extended_superframe, j1_superframe});
            rd_chk("framing readback", FS_A, {24'h0, d});
        end
        $display("test framing done");

        sig_send(4'h5, 4'h3);
        check_val("sig immediate", 32'h53, {24'h0, receive_signalling_out, tx_sig_out});
        wr(FS_A, 8'h80);
        sig_send(4'hA, 4'hC);
        repeat (3) @(posedge clock);
        @(negedge clock);
        check_val("sig deferred", 32'h53, {24'h0, receive_signalling_out, tx_sig_out});
        @(posedge clock);
        rx_sf_boundary <= 1'b1;
        tx_sf_boundary <= 1'b1;
        @(posedge clock);
        rx_sf_boundary <= 1'b0;
        tx_sf_boundary <= 1'b0;
        @(negedge clock);
        check_val("sig boundary", 32'hAC, {24'h0, receive_signalling_out, tx_sig_out});
        rd_chk("sig array", SIG_A, 32'hA);
        $display("test signalling done");

        apb(1'b1, 12'h010, 32'hFF);
        check_val("unmapped write err", 32'h1, {31'h0, rerr});
        rd_chk("unmapped read", 12'h010, 32'h0);
        check_val("unmapped read err", 32'h1, {31'h0, rerr});
        rd_chk("line after unmapped", LINE_A, 32'h00);
        $display("test unmapped done");
        summarize();
    end

endmodule // t1_framer_control_bank_tb_top

`default_nettype wire
